/* File: design/ppcs_top.sv */
// management command slave of a power supply on a two-wire pec-protected link
`timescale 1ns/100ps
// Summary of operation
// - match prefix, low address bits from straps
// - address lsb: zero write, one read
// - broadcast address accepted for writes only
// - broadcast write executes like own address
// - one strap setting shared by all targets
// - write: command, zero to three data, pec
// - multi-byte values low byte first, except the alarm word, sent high byte first
// - pec covers address, command and data
// - values in direct format with constants
// - output voltage scaled m 400, b0, r0
// - operation command switches main output
// - operation data 0x80 on, 0x00 off
// - output on after power-up when enabled
// - restart clears alarms and latched shutdowns
// - clear faults resets six status flags
// - alert asserted on first state change
// - frames of supported commands without pec are ignored
// - pec is crc-8, x^8+x^2+x+1
// - stretch at most 25 ms, host honours
// - unsupported code sets invalid flag, alert
module ppcs_top
(
  // clocks and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic scl_clk,
  // two-wire data pin, open drain
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // alert pin, open drain, active low on the wire
  output logic alert_n_out,
  output logic alert_n_oe,
  // address straps and enable pin
  input wire logic addr_strap_hi,
  input wire logic addr_strap_mid,
  input wire logic addr_strap_lo,
  input wire logic enable_n,
  // supply state from local logic
  input wire logic [15:0] alarm_in,
  input wire logic [15:0] vout_meas,
  input wire logic [7:0] iout_meas,
  input wire logic [7:0] temp_meas,
  input wire logic shutdown_evt,
  input wire logic iso_ok_evt,
  input wire logic iso_fail_evt,
  input wire logic pwr_cap_hi,
  input wire logic int_fault,
  // controls toward the power stage
  output logic out_on,
  output logic [15:0] vout_set,
  output logic [15:0] ov_limit,
  output logic service_led,
  output logic led_test,
  // status view
  output logic [7:0] status_2,
  output logic [7:0] status_1
);
  import ppcs_pkg::*;

  // ==========================================================================
  // state
  typedef struct packed
  {
    ppcs_state_t st;
    logic scl_s1;
    logic scl_s2;
    logic scl_s3;
    logic sda_s1;
    logic sda_s2;
    logic sda_s3;
    logic en_s1;
    logic en_s2;
    logic [2:0] strap_s1;
    logic [2:0] strap_s2;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic [3:0] nbyte;
    logic [3:0] idx;
    logic rd;
    logic wr_ok;
    logic ack;
    logic oe;
    logic [7:0] cmd;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    logic on;
    logic on_prev;
    logic shut;
    logic pec_err;
    logic invalid;
    logic comm_err;
    logic rst_ok;
    logic iso_ok;
    logic iso_fail;
    logic alert;
    logic svc;
    logic ledt;
    logic auto_rst;
    logic [15:0] vout;
    logic [15:0] ovl;
    logic [15:0] alarm_prev;
  } ppcs_regs_t;

  ppcs_regs_t q; // registered state
  ppcs_regs_t d; // next state

  // link-side capture, clocked by the link clock
  typedef struct packed
  {
    logic bit_q;
  } ppcs_link_t;

  ppcs_link_t lk; // data bit caught on the rising link clock

  ppcs_pec_if pec_if (); // carrier to the crc engine

  // ==========================================================================
  // decoded events in the main domain
  logic scl_rise; // link clock rose, captured bit is stable
  logic scl_fall; // link clock fell, time to change sda
  logic start_c; // start or repeated start
  logic stop_c; // stop condition
  logic [7:0] byte_in; // byte completed by the current bit
  logic [7:0] txb; // next byte to send
  logic addr_me; // controller target addressed
  logic bcast; // broadcast address
  logic [3:0] nrx; // bytes after the address
  logic [2:0] info; // command table entry
  logic [3:0] need; // bytes expected with pec
  logic exec; // frame passed every check
  logic clr_faults; // clear faults executed
  logic rd_done; // status block fully read
  logic restart; // output cycled back on
  logic on_now; // output commanded on and enabled
  logic set_pec, set_inv, set_comm; // flag set events
  logic state_chg; // any supply state change other than turn-on

  assign scl_rise = q.scl_s2 & ~q.scl_s3;
  assign scl_fall = q.scl_s3 & ~q.scl_s2;
  assign start_c = q.scl_s2 & q.scl_s3 & q.sda_s3 & ~q.sda_s2;
  assign stop_c = q.scl_s2 & q.scl_s3 & ~q.sda_s3 & q.sda_s2;
  assign byte_in = {q.sh[6:0], lk.bit_q};
  assign nrx = q.nbyte - 4'h1;
  assign info = ppcs_cmd_info(q.cmd);
  assign need = {2'b00, info[1:0]} + 4'h2;
  assign on_now = q.on & ~q.en_s2;

  // ==========================================================================
  // link clock domain: sda sampled on the rising edge and held for a bit time;
  // the main domain reads it only after the synchronised rise, so it is stable
  always_ff @(posedge scl_clk)
  begin
    lk.bit_q <= sda_in;
  end

  // ==========================================================================
  // address decode
  always_comb
  begin
    // prefix match, straps supply low bits
    // the same strap copy serves every target
    addr_me = (byte_in[7:4] == MCU_PREFIX) && (byte_in[3:1] == q.strap_s2);
    // broadcast only ever reaches the controller target
    bcast = (byte_in[7:1] == BCAST_ADDR);
  end

  // ==========================================================================
  // read-back byte source
  always_comb
  begin
    txb = TX_FILL;
    if (q.cmd == CMD_READ_STATUS)
    begin
      // analog words go low byte first
      case (q.idx)
        4'h0: txb = RS_COUNT;
        4'h1: txb = status_2;
        4'h2: txb = status_1;
        4'h3: txb = alarm_in[15:8];
        4'h4: txb = alarm_in[7:0];
        4'h5: txb = vout_meas[7:0];
        4'h6: txb = vout_meas[15:8];
        4'h7: txb = iout_meas;
        4'h8: txb = temp_meas;
        4'ha: txb = pec_if.crc;
        default: txb = TX_FILL;
      endcase
    end
  end

  // ==========================================================================
  // next state
  always_comb
  begin
    d = q;
    pec_if.clr = 1'b0;
    pec_if.ld = 1'b0;
    pec_if.data = byte_in;
    exec = 1'b0;
    clr_faults = 1'b0;
    rd_done = 1'b0;
    set_pec = 1'b0;
    set_inv = 1'b0;
    set_comm = 1'b0;
    // pin synchronisers, first stage feeds only the second
    d.scl_s1 = scl_clk;
    d.scl_s2 = q.scl_s1;
    d.scl_s3 = q.scl_s2;
    d.sda_s1 = sda_in;
    d.sda_s2 = q.sda_s1;
    d.sda_s3 = q.sda_s2;
    d.en_s1 = enable_n;
    d.en_s2 = q.en_s1;
    d.strap_s1 = {addr_strap_hi, addr_strap_mid, addr_strap_lo};
    d.strap_s2 = q.strap_s1;

    case (q.st)
      ST_IDLE:
      begin
        d.oe = 1'b0;
      end
      ST_RX:
      begin
        if (scl_rise && q.cnt != 4'h8)
        begin
          d.sh = byte_in;
          d.cnt = q.cnt + 4'h1;
          if (q.cnt == 4'h7)
          begin
            // every byte of the frame folds into the crc
            pec_if.ld = 1'b1;
            if (q.nbyte != 4'hf)
              d.nbyte = q.nbyte + 4'h1;
            if (q.nbyte == 4'h0)
            begin
              d.rd = byte_in[0];
              d.ack = addr_me | (bcast & ~byte_in[0]);
              d.wr_ok = ~byte_in[0] & (addr_me | bcast);
              d.idx = 4'h0;
            end
            else
            begin
              d.ack = 1'b1;
              case (q.nbyte)
                4'h1: d.cmd = byte_in;
                4'h2: d.b1 = byte_in;
                4'h3: d.b2 = byte_in;
                default: d.b3 = byte_in;
              endcase
            end
          end
        end
        if (scl_fall && q.cnt == 4'h8)
        begin
          // ack drives sda low through the ninth clock
          d.oe = q.ack;
          d.st = q.ack ? ST_ACK : ST_SKIP;
        end
      end
      ST_ACK, ST_TXACK:
      begin
        if (q.st == ST_TXACK && scl_rise)
          d.ack = ~lk.bit_q;
        if (scl_fall)
        begin
          d.cnt = 4'h0;
          d.oe = 1'b0;
          if (q.st == ST_TXACK && !q.ack)
          begin
            // host nack ends the read; a full status block clears alert
            d.st = ST_SKIP;
            rd_done = (q.cmd == CMD_READ_STATUS) && (q.idx > RS_PEC_IDX);
          end
          else if (q.rd)
          begin
            d.st = ST_TX;
            d.sh = txb;
            d.oe = ~txb[7];
            d.cnt = 4'h1;
            if (q.idx != 4'hf)
              d.idx = q.idx + 4'h1;
            pec_if.ld = (q.idx < RS_PEC_IDX);
            pec_if.data = txb;
          end
          else
          begin
            d.st = ST_RX;
          end
        end
      end
      ST_TX:
      begin
        if (scl_fall)
        begin
          if (q.cnt == 4'h8)
          begin
            d.oe = 1'b0;
            d.st = ST_TXACK;
          end
          else
          begin
            d.sh = {q.sh[6:0], 1'b0};
            d.oe = ~q.sh[6];
            d.cnt = q.cnt + 4'h1;
          end
        end
      end
      ST_SKIP:
      begin
        d.oe = 1'b0;
      end
      default:
      begin
        d.st = ST_IDLE;
        d.oe = 1'b0;
      end
    endcase

    // frame boundaries override the bit machine
    if (start_c)
    begin
      // a fresh start restarts the crc, a repeated one keeps it
      pec_if.clr = (q.st == ST_IDLE);
      d.st = ST_RX;
      d.cnt = 4'h0;
      d.nbyte = 4'h0;
      d.oe = 1'b0;
      if (q.st == ST_IDLE)
        d.wr_ok = 1'b0;
    end
    else if (stop_c)
    begin
      d.st = ST_IDLE;
      d.oe = 1'b0;
      d.wr_ok = 1'b0;
      if (q.wr_ok && !q.rd && q.nbyte >= 4'h2)
      begin
        if (!info[2])
          set_inv = 1'b1;
        else if (nrx == need)
        begin
          if (pec_if.crc == 8'h00)
            exec = 1'b1;
          else
            set_pec = 1'b1;
        end
        else if (nrx != need - 4'h1)
          // any other length is a communication error
          set_comm = 1'b1;
      end
    end

    // broadcast writes execute here like addressed ones
    if (exec)
    begin
      case (q.cmd)
        CMD_OPERATION:
        begin
          // 0x80 on, 0x00 off, other data refused
          if (q.b1 == OP_ON)
            d.on = 1'b1;
          else if (q.b1 == OP_OFF)
            d.on = 1'b0;
          else
            set_comm = 1'b1;
        end
        CMD_CLEAR_FAULTS: clr_faults = 1'b1;
        // output voltage code is volts times 400
        CMD_VOUT: d.vout = {q.b2, q.b1};
        CMD_OV_LIMIT: d.ovl = {q.b2, q.b1};
        CMD_LED_TEST_ON: d.ledt = 1'b1;
        CMD_LED_TEST_OFF: d.ledt = 1'b0;
        CMD_SVC_LED_ON: d.svc = 1'b1;
        CMD_SVC_LED_OFF: d.svc = 1'b0;
        CMD_INHIBIT_RST: d.auto_rst = 1'b0;
        CMD_AUTO_RST: d.auto_rst = 1'b1;
        default: d.auto_rst = q.auto_rst;
      endcase
    end

    // restart: output comes back on after being off, by pin or command
    d.on_prev = on_now;
    restart = on_now & ~q.on_prev;

    // status flags, set wins over clear
    // restart clears alarms and the shutdown latch
    d.shut = shutdown_evt | (q.shut & ~restart);
    d.pec_err = set_pec | (q.pec_err & ~(clr_faults | restart));
    d.comm_err = set_comm | (q.comm_err & ~(clr_faults | restart));
    d.invalid = set_inv | (q.invalid & ~(clr_faults | restart));
    d.iso_ok = iso_ok_evt | (q.iso_ok & ~clr_faults);
    d.iso_fail = iso_fail_evt | (q.iso_fail & ~clr_faults);
    d.rst_ok = restart | (q.rst_ok & ~clr_faults);

    // alert on the first change, no settling wait
    d.alarm_prev = alarm_in;
    state_chg = (alarm_in != q.alarm_prev) | shutdown_evt | (q.on_prev & ~on_now)
      | set_pec | set_inv | set_comm | iso_ok_evt | iso_fail_evt;
    // a clear with alarms still standing re-latches at once
    d.alert = state_chg | (q.alert & ~(clr_faults | rd_done | restart))
      | ((clr_faults | rd_done) & (|alarm_in));
  end

  // ==========================================================================
  // state register
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.st <= ST_IDLE;
      q.scl_s1 <= 1'b1;
      q.scl_s2 <= 1'b1;
      q.scl_s3 <= 1'b1;
      q.sda_s1 <= 1'b1;
      q.sda_s2 <= 1'b1;
      q.sda_s3 <= 1'b1;
      q.en_s1 <= 1'b1;
      q.en_s2 <= 1'b1;
      // output defaults on, gated by the enable pin
      q.on <= OUT_ON_RST;
      // starts low so the enable sync settling is not taken for a turn-off
      q.on_prev <= 1'b0;
      q.auto_rst <= AUTO_RST_RST;
      q.vout <= VOUT_SET_RST;
      q.ovl <= OV_LIMIT_RST;
    end
    else
    begin
      q <= d;
    end
  end

  // ==========================================================================
  // pec engine
  ppcs_pec u_pec
  (
    .mclk (mclk),
    .rst_n (rst_n),
    .pif (pec_if)
  );

  // ==========================================================================
  // outputs; the slave never stretches the clock, so the 25 ms
  // ceiling holds trivially
  // no clock stretching performed
  assign sda_out = 1'b0;
  assign sda_oe = q.oe;
  assign alert_n_out = 1'b0;
  assign alert_n_oe = q.alert;
  assign out_on = q.on & ~q.en_s2 & ~q.shut;
  assign vout_set = q.vout;
  assign ov_limit = q.ovl;
  assign service_led = q.svc;
  assign led_test = q.ledt;
  assign status_2 = {q.pec_err, q.auto_rst, q.invalid, pwr_cap_hi,
                     q.iso_fail, q.rst_ok, q.comm_err, q.en_s2};
  assign status_1 = {1'b0, q.iso_ok, int_fault, q.shut,
                     q.svc, 1'b0, q.ledt, out_on};

endmodule

/* File: design/ppcs_pkg.sv */
// shared constants, types and command table of the power supply command slave
package ppcs_pkg;

  // ==========================================================================
  // addressing
  localparam logic [3:0] MCU_PREFIX = 4'h8;
  localparam logic [6:0] BCAST_ADDR = 7'h00;

  // ==========================================================================
  // packet error check, crc-8 with x^8 + x^2 + x + 1
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_RST = 8'h00;

  // ==========================================================================
  // command codes
  localparam logic [7:0] CMD_OPERATION = 8'h01;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_VOUT = 8'h21;
  localparam logic [7:0] CMD_OV_LIMIT = 8'h40;
  localparam logic [7:0] CMD_READ_STATUS = 8'hd0;
  localparam logic [7:0] CMD_LED_TEST_ON = 8'hd2;
  localparam logic [7:0] CMD_LED_TEST_OFF = 8'hd3;
  localparam logic [7:0] CMD_SVC_LED_ON = 8'hd4;
  localparam logic [7:0] CMD_SVC_LED_OFF = 8'hd5;
  localparam logic [7:0] CMD_INHIBIT_RST = 8'hd8;
  localparam logic [7:0] CMD_AUTO_RST = 8'hd9;

  // operation data byte values
  localparam logic [7:0] OP_ON = 8'h80;
  localparam logic [7:0] OP_OFF = 8'h00;

  // ==========================================================================
  // direct format scaling of output voltage: code = volts * m, b = 0, r = 0
  localparam int VOUT_M = 400;
  localparam int VOUT_B = 0;
  localparam int VOUT_R = 0;

  // ==========================================================================
  // reset values
  localparam logic [15:0] VOUT_SET_RST = 16'h0000;
  localparam logic [15:0] OV_LIMIT_RST = 16'h0000;
  localparam logic OUT_ON_RST = 1'b1;
  localparam logic AUTO_RST_RST = 1'b1;

  // ==========================================================================
  // status block read back
  localparam logic [7:0] RS_COUNT = 8'h09;
  localparam logic [3:0] RS_PEC_IDX = 4'ha;
  localparam logic [7:0] TX_FILL = 8'hff;

  // ==========================================================================
  // link state machine, one-hot
  typedef enum logic [5:0]
  {
    ST_IDLE = 6'h01,
    ST_RX = 6'h02,
    ST_ACK = 6'h04,
    ST_TX = 6'h08,
    ST_TXACK = 6'h10,
    ST_SKIP = 6'h20
  } ppcs_state_t;

  // pec engine state
  typedef struct packed
  {
    logic [7:0] crc;
  } ppcs_pec_t;

  // ==========================================================================
  // command table: {supported, data bytes of a write}
  function automatic logic [2:0] ppcs_cmd_info(input logic [7:0] code);
    logic [2:0] r;
    r = 3'h0;
    case (code)
      8'h01: r = 3'h5;
      8'h03, 8'hd0, 8'hd2, 8'hd3, 8'hd4, 8'hd5, 8'hd6, 8'hd7: r = 3'h4;
      8'hd8, 8'hd9, 8'hda, 8'hdc, 8'hdd, 8'hde, 8'he0, 8'he1, 8'he2: r = 3'h4;
      8'h21, 8'h40: r = 3'h6;
      8'hdf: r = 3'h7;
      default: r = 3'h0;
    endcase
    return r;
  endfunction

endpackage

/* File: design/ppcs_pec_if.sv */
// carrier between the command slave and its packet error check engine
`timescale 1ns/100ps
interface ppcs_pec_if;
  logic clr;
  logic ld;
  logic [7:0] data;
  logic [7:0] crc;
  modport engine (input clr, input ld, input data, output crc);
  modport user (output clr, output ld, output data, input crc);
endinterface

/* File: design/ppcs_pec.sv */
// byte-wide crc-8 accumulator for the packet error check
`timescale 1ns/100ps
module ppcs_pec
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // byte feed and result
  ppcs_pec_if.engine pif
);
  import ppcs_pkg::*;

  ppcs_pec_t q; // registered crc
  ppcs_pec_t d; // next crc

  // ==========================================================================
  // one byte folded per load, msb first
  always_comb
  begin
    d = q;
    if (pif.clr)
    begin
      d.crc = CRC_RST;
    end
    else if (pif.ld)
    begin
      d.crc = q.crc ^ pif.data;
      for (int i = 0; i < 8; i++)
      begin
        d.crc = d.crc[7] ? ({d.crc[6:0], 1'b0} ^ CRC_POLY) : {d.crc[6:0], 1'b0};
      end
    end
  end

  // ==========================================================================
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      q <= '{crc: CRC_RST};
    else
      q <= d;
  end

  assign pif.crc = q.crc;

endmodule

/* File: bench/ppcs_top_monitor.sv */
// port level checks of the command slave
`timescale 1ns/100ps
module ppcs_top_monitor
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // link, pins and outputs
  input wire logic scl_clk,
  input wire logic sda_oe,
  input wire logic alert_n_oe,
  input wire logic enable_n,
  input wire logic [15:0] alarm_in,
  input wire logic out_on,
  input wire logic [15:0] vout_set,
  input wire logic [15:0] ov_limit,
  input wire logic [7:0] status_2
);
  // one domain, so one clock and one disable for all
  default clocking
    @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // ==========================================================================
  // link and execution
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_clk)
    else $error("data pin moved while scl high");
  // settings change only after stop, with scl parked high
  a_exec_at_stop: assert property ($changed(vout_set) || $changed(ov_limit) |-> scl_clk)
    else $error("setting changed inside a frame");
  a_pec_no_exec: assert property ($rose(status_2[7]) |-> $stable(vout_set) && $stable(ov_limit))
    else $error("bad pec frame executed");
  // ==========================================================================
  // alert
  a_pec_alert: assert property ($rose(status_2[7]) |-> ##[0:2] alert_n_oe)
    else $error("pec error without alert");
  a_inval_alert: assert property ($rose(status_2[5]) |-> ##[0:2] alert_n_oe)
    else $error("invalid command without alert");
  a_len_alert: assert property ($rose(status_2[1]) |-> ##[0:2] alert_n_oe)
    else $error("length error without alert");
  a_alarm_alert: assert property ($changed(alarm_in) |-> ##[1:4] alert_n_oe)
    else $error("alarm change without alert");
  // ==========================================================================
  // output control
  // two-stage synchroniser gives two cycles, five allowed
  a_en_off: assert property (enable_n [*5] |-> !out_on)
    else $error("output on with enable pin high");
  a_restart_clr: assert property ($rose(out_on) |-> ##[0:2] !status_2[7] && !status_2[1])
    else $error("restart left error flags set");
  // main scenarios
  c_inval: cover property ($rose(status_2[5]));
  c_off: cover property ($fell(out_on));
  c_vout: cover property ($changed(vout_set));
endmodule
bind ppcs_top ppcs_top_monitor i_ppcs_top_monitor
(
  .mclk(mclk), .rst_n(rst_n), .scl_clk(scl_clk), .sda_oe(sda_oe),
  .alert_n_oe(alert_n_oe), .enable_n(enable_n), .alarm_in(alarm_in),
  .out_on(out_on), .vout_set(vout_set), .ov_limit(ov_limit), .status_2(status_2)
);

/* File: bench/ppcs_host.sv */
// host model: two-wire master, clock stands high between frames
`timescale 1ns/100ps
module ppcs_host
(
  // link pins
  output logic scl,
  output logic sda_oe,
  input wire logic sda
);
  // half period of the 160 ns link clock
  localparam int HP = 80;
  initial
  begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  // start or repeated start; odd offset keeps phase unrelated
  // frame start
  task automatic start();
    #3;
    sda_oe = 1'b0;
    #(HP);
    scl = 1'b1;
    #(HP);
    sda_oe = 1'b1;
    #(HP);
    scl = 1'b0;
  endtask
  // data set with scl low, read back just before the fall
  task automatic bit_x(input logic b, output logic r);
    sda_oe = ~b;
    #(HP);
    scl = 1'b1;
    #(HP);
    r = sda;
    scl = 1'b0;
  endtask
  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask
  task automatic rd(input logic nak, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(nak, r);
  endtask
  task automatic stop();
    sda_oe = 1'b1;
    #(HP);
    scl = 1'b1;
    #(HP);
    sda_oe = 1'b0;
    #(HP);
  endtask
endmodule

/* File: bench/ppcs_top_test.sv */
// self-checking bench of the command slave
`timescale 1ns/100ps
module ppcs_top_test;
  import ppcs_pkg::*;
  // ==========================================================================
  // signals
  logic mclk = 1'b0, rst_n = 1'b0, scl, h_oe, d_oe, sda_w, sda_out;
  logic alert_n_out, alert_n_oe, out_on, service_led, led_test;
  logic s_hi = 1'b1, s_mid = 1'b0, s_lo = 1'b1, enable_n = 1'b0;
  logic shutdown_evt = 1'b0, iso_ok_evt = 1'b0, iso_fail_evt = 1'b0;
  logic [15:0] alarm_in = 16'h0000, vout_set, ov_limit;
  logic [7:0] status_2, status_1, aw;
  logic [7:0] fq[$];
  logic ack0;
  int fail_count = 0;
  int n_tests = 0;
  // pulled-up wire: low while either side pulls
  assign sda_w = ~(d_oe | h_oe);
  assign aw = {MCU_PREFIX, s_hi, s_mid, s_lo, 1'b0};
  always #5 mclk = ~mclk;
  ppcs_top i_ppcs_top
  (
    .mclk(mclk), .rst_n(rst_n), .scl_clk(scl), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe(d_oe), .alert_n_out(alert_n_out), .alert_n_oe(alert_n_oe),
    .addr_strap_hi(s_hi), .addr_strap_mid(s_mid), .addr_strap_lo(s_lo),
    .enable_n(enable_n), .alarm_in(alarm_in), .vout_meas(16'h1357),
    .iout_meas(8'h24), .temp_meas(8'h2a), .shutdown_evt(shutdown_evt),
    .iso_ok_evt(iso_ok_evt), .iso_fail_evt(iso_fail_evt), .pwr_cap_hi(1'b0),
    .int_fault(1'b0), .out_on(out_on), .vout_set(vout_set), .ov_limit(ov_limit),
    .service_led(service_led), .led_test(led_test), .status_2(status_2),
    .status_1(status_1)
  );
  ppcs_host i_ppcs_host (.scl(scl), .sda_oe(h_oe), .sda(sda_w));
  // ==========================================================================
  // helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++)
      r = r[7] ? {r[6:0], 1'b0} ^ 8'h07 : {r[6:0], 1'b0};
    return r;
  endfunction
  // write frame of fq; pm 0 no pec, 1 good pec, 2 corrupt pec
  task automatic frame(input int pm);
    logic [7:0] c;
    logic a;
    c = 8'h00;
    i_ppcs_host.start();
    foreach (fq[i])
    begin
      c = crc8(c, fq[i]);
      i_ppcs_host.wr(fq[i], a);
      if (i == 0)
        ack0 = a;
    end
    if (pm != 0)
      i_ppcs_host.wr(pm == 2 ? ~c : c, a);
    i_ppcs_host.stop();
    // execution lands a few cycles after stop
    repeat (8) @(negedge mclk);
  endtask
  task automatic pulse(input int k);
    @(negedge mclk);
    {shutdown_evt, iso_fail_evt, iso_ok_evt} = 3'(k);
    @(negedge mclk);
    {shutdown_evt, iso_fail_evt, iso_ok_evt} = 3'h0;
    repeat (3) @(negedge mclk);
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_vout();
    check(out_on, 1'b1);
    check(vout_set, VOUT_SET_RST);
    fq = '{aw, CMD_VOUT, 8'hd4, 8'h4e};
    frame(1);
    check(ack0, 1'b1);
    check(vout_set, 16'(400 * 5045 / 100));
  endtask
  task automatic t_addr();
    logic a;
    fq = '{8'h8c, CMD_VOUT, 8'h11, 8'h22};
    frame(1);
    check(ack0, 1'b0);
    check(vout_set, 16'h4ed4);
    i_ppcs_host.start();
    i_ppcs_host.wr(8'h01, a);
    i_ppcs_host.stop();
    check(a, 1'b0);
    s_mid = 1'b1;
    repeat (4) @(negedge mclk);
    fq = '{aw, CMD_OV_LIMIT, 8'h34, 8'h12};
    frame(1);
    check(ov_limit, 16'h1234);
  endtask
  task automatic t_inval();
    pulse(3);
    fq = '{aw, 8'h55};
    frame(1);
    check({status_2[5], status_2[3], status_1[6]}, 3'h7);
    fq = '{aw, CMD_CLEAR_FAULTS};
    frame(1);
    check({status_2[5], status_2[3], status_2[2], status_1[6]}, 4'h0);
    fq = '{aw, CMD_SVC_LED_ON};
    frame(1);
    fq = '{aw, CMD_LED_TEST_ON};
    frame(1);
    fq = '{aw, CMD_INHIBIT_RST};
    frame(1);
    check({service_led, led_test, status_2[6], status_1[3], status_1[1]}, 5'h1b);
  endtask
  task automatic t_errs();
    fq = '{aw, CMD_OV_LIMIT, 8'h78, 8'h56};
    frame(2);
    check({status_2[7], alert_n_oe}, 2'h3);
    check(ov_limit, 16'h1234);
    frame(0);
    check(ov_limit, 16'h1234);
    fq = '{aw, CMD_VOUT, 8'h01, 8'h02, 8'h03};
    frame(1);
    check(status_2[1], 1'b1);
    check(vout_set, 16'h4ed4);
  endtask
  task automatic t_restart();
    pulse(4);
    check(out_on, 1'b0);
    fq = '{8'h00, CMD_OPERATION, OP_OFF};
    frame(1);
    check(out_on, 1'b0);
    fq = '{8'h00, CMD_OPERATION, OP_ON};
    frame(1);
    check({out_on, status_2[2]}, 2'h3);
    check({status_1[4], status_2[7], status_2[1]}, 3'h0);
    enable_n = 1'b1;
    repeat (6) @(negedge mclk);
    check(out_on, 1'b0);
    enable_n = 1'b0;
    repeat (6) @(negedge mclk);
    check(out_on, 1'b1);
  endtask
  task automatic t_read();
    logic a;
    logic [7:0] c;
    logic [7:0] rb[11];
    alarm_in = 16'h0a05;
    repeat (5) @(negedge mclk);
    check(alert_n_oe, 1'b1);
    i_ppcs_host.start();
    i_ppcs_host.wr(aw, a);
    i_ppcs_host.wr(CMD_READ_STATUS, a);
    i_ppcs_host.start();
    i_ppcs_host.wr(aw | 8'h01, a);
    check(a, 1'b1);
    c = crc8(crc8(crc8(8'h00, aw), CMD_READ_STATUS), aw | 8'h01);
    foreach (rb[i])
    begin
      i_ppcs_host.rd(i == 10, rb[i]);
      if (i < 10)
        c = crc8(c, rb[i]);
    end
    i_ppcs_host.stop();
    check(rb[0], 8'h09);
    check({rb[3], rb[4]}, 16'h0a05);
    check({rb[6], rb[5]}, 16'h1357);
    check(rb[9], TX_FILL);
    check(rb[10], c);
  endtask
  // ==========================================================================
  // run control
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    t_vout();
    t_addr();
    t_inval();
    t_errs();
    t_restart();
    t_read();
    complete_run();
  end
  // watchdog well beyond the fifteen frames
  initial
  begin
    #(400000);
    fail_count++;
    complete_run();
  end
endmodule
